// >>> logic/cil_pkg.sv
// Package: register map, field layout and helpers for the configuration image loader
package cil_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_KEY   = 8'h04;
  localparam logic [7:0] OFF_STAT  = 8'h08;
  localparam logic [7:0] OFF_WORDS = 8'h0c;
  localparam logic [7:0] OFF_LAST  = 8'h10;

  // Control register fields
  localparam int unsigned CTRL_WID_LO  = 0;
  localparam int unsigned CTRL_DCMP    = 2;
  localparam int unsigned CTRL_DCRY    = 3;
  localparam int unsigned CTRL_SERIAL  = 4;
  localparam int unsigned CTRL_QUAD    = 5;
  localparam int unsigned CTRL_SET_LO  = 6;
  localparam int unsigned CTRL_CHAIN   = 8;
  localparam int unsigned CTRL_USRCLK  = 9;
  localparam int unsigned CTRL_RUN     = 10;
  localparam int unsigned CTRL_BITS    = 11;

  // Status register fields
  localparam int unsigned STAT_INITOPT = 0;
  localparam int unsigned STAT_RUN     = 1;
  localparam int unsigned STAT_RAT_LO  = 4;

  // Reset values
  localparam logic [10:0] CTRL_RESET = 11'h000;
  localparam logic [31:0] KEY_RESET  = 32'h0000_0000;

  // Parallel word widths
  localparam logic [1:0] WID_8  = 2'h0;
  localparam logic [1:0] WID_16 = 2'h1;
  localparam logic [1:0] WID_32 = 2'h2;

  // Serial clock settings
  localparam logic [1:0] SET_TOP   = 2'h3;
  localparam logic [1:0] SET_CHAIN = 2'h2;

  // Flash read commands and their length
  localparam logic [7:0] CMD_READ_X1 = 8'h03;
  localparam logic [7:0] CMD_READ_X4 = 8'heb;
  localparam logic [5:0] CMD_BITS    = 6'h08;
  localparam logic [5:0] WORD_BITS   = 6'h20;

  // Option bit in the first image word that enables the init-done pin
  localparam int unsigned OPT_INIT_DONE = 0;

  typedef enum logic [1:0] {
    SER_IDLE = 2'b00,
    SER_CMD  = 2'b01,
    SER_DATA = 2'b10
  } cil_ser_state_t;

  // Link clock cycles per parallel word
  function automatic logic [3:0] word_ratio(input logic [1:0] wid, input logic dcmp,
                                            input logic dcry);
    logic [3:0] r;
    r = 4'h1;
    case (wid)
      WID_8:   r = dcmp ? 4'h2 : 4'h1;
      WID_16:  r = dcmp ? 4'h4 : (dcry ? 4'h2 : 4'h1);
      WID_32:  r = dcmp ? 4'h8 : (dcry ? 4'h4 : 4'h1);
      default: r = 4'h1;
    endcase
    return r;
  endfunction

  // Oscillator half periods per clock setting, slowest first
  function automatic logic [3:0] half_cycles(input logic [1:0] set);
    logic [3:0] h;
    h = 4'h8;
    case (set)
      2'h0:    h = 4'h8;
      2'h1:    h = 4'h4;
      2'h2:    h = 4'h2;
      default: h = 4'h1;
    endcase
    return h;
  endfunction

  // Keeps only the data lines in use for the width
  function automatic logic [31:0] mask_word(input logic [31:0] w, input logic [1:0] wid);
    logic [31:0] m;
    m = w;
    case (wid)
      WID_8:   m = {24'h000000, w[7:0]};
      WID_16:  m = {16'h0000, w[15:0]};
      default: m = w;
    endcase
    return m;
  endfunction

endpackage

// >>> logic/cil_serial_reader.sv
// Serial flash reader on the link clock: command out, one or four bits in
`timescale 1ns/10ps
module cil_serial_reader (
  // Link clock and reset
  input  wire logic        lclk,
  input  wire logic        lrst_n,
  // Control
  input  wire logic        run,
  input  wire logic        quad,
  input  wire logic [1:0]  clkset,
  // Flash pins
  output logic             flash_clk,
  output logic             cmd_out,
  output logic             cmd_oe,
  input  wire logic [3:0]  data_in,
  // Assembled words
  output logic             word_vld,
  output logic [31:0]      word
);

  cil_pkg::cil_ser_state_t st_q, st_d;
  logic [3:0]  half_q, half_d;
  logic        fclk_q, fclk_d;
  logic [5:0]  cnt_q, cnt_d;
  logic [7:0]  cmd_q, cmd_d;
  logic [31:0] sh_q, sh_d;
  logic        cout_q, cout_d;
  logic        coe_q, coe_d;
  logic        vld_q, vld_d;
  logic        fall;

  // Both launch and sample happen where the generated clock falls
  assign fall = (half_q == 4'h0) && fclk_q; // RQ11

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    st_d   = st_q;
    half_d = half_q;
    fclk_d = fclk_q;
    cnt_d  = cnt_q;
    cmd_d  = cmd_q;
    sh_d   = sh_q;
    cout_d = cout_q;
    coe_d  = coe_q;
    vld_d  = 1'b0;
    if (!run)
    begin
      st_d   = cil_pkg::SER_IDLE;
      fclk_d = 1'b0;
      coe_d  = 1'b0;
      half_d = 4'(cil_pkg::half_cycles(clkset) - 4'h1); // RQ7
    end
    else
    begin
      if (half_q == 4'h0)
      begin
        half_d = 4'(cil_pkg::half_cycles(clkset) - 4'h1); // RQ7
        fclk_d = ~fclk_q;
      end
      else
      begin
        half_d = half_q - 4'h1;
      end
      case (st_q)
        cil_pkg::SER_IDLE:
        begin
          st_d  = cil_pkg::SER_CMD;
          cmd_d = quad ? cil_pkg::CMD_READ_X4 : cil_pkg::CMD_READ_X1;
          cnt_d = 6'h00;
          coe_d = 1'b1;
        end
        cil_pkg::SER_CMD:
        begin
          if (fall && cnt_q == cil_pkg::CMD_BITS)
          begin
            coe_d = 1'b0;
            cnt_d = 6'h00;
            st_d  = cil_pkg::SER_DATA;
          end
          else if (fall)
          begin
            cout_d = cmd_q[7]; // RQ11
            cmd_d  = {cmd_q[6:0], 1'b0};
            cnt_d  = cnt_q + 6'h01;
          end
        end
        cil_pkg::SER_DATA:
        begin
          if (fall)
          begin
            // Four lines in quad mode, one line otherwise
            sh_d  = quad ? {sh_q[27:0], data_in} : {sh_q[30:0], data_in[1]}; // RQ6 RQ11
            cnt_d = cnt_q + (quad ? 6'h04 : 6'h01);
            if (cnt_d == cil_pkg::WORD_BITS)
            begin
              vld_d = 1'b1;
              cnt_d = 6'h00;
            end
          end
        end
        default: st_d = cil_pkg::SER_IDLE;
      endcase
    end
  end

  always_ff @(posedge lclk or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      st_q   <= cil_pkg::SER_IDLE;
      half_q <= 4'h0;
      fclk_q <= 1'b0;
      cnt_q  <= 6'h00;
      cmd_q  <= 8'h00;
      sh_q   <= 32'h0000_0000;
      cout_q <= 1'b0;
      coe_q  <= 1'b0;
      vld_q  <= 1'b0;
    end
    else
    begin
      st_q   <= st_d;
      half_q <= half_d;
      fclk_q <= fclk_d;
      cnt_q  <= cnt_d;
      cmd_q  <= cmd_d;
      sh_q   <= sh_d;
      cout_q <= cout_d;
      coe_q  <= coe_d;
      vld_q  <= vld_d;
    end
  end

  assign flash_clk = fclk_q;
  assign cmd_out   = cout_q;
  assign cmd_oe    = coe_q;
  assign word_vld  = vld_q;
  assign word      = sh_q;

  ////////////////////////////////////////////////////////////////////////////
  a_clk_half_period: assert property ( // RQ7
    @(posedge lclk) disable iff (!lrst_n || !run)
    ($rose(fclk_q) && $past(clkset) == 2'h1) |-> fclk_q[*4] ##1 !fclk_q)
    else $error("flash clock high time differs from the setting");

  a_launch_on_fall: assert property ( // RQ11
    @(posedge lclk) disable iff (!lrst_n)
    $changed(cout_q) |-> $fell(fclk_q))
    else $error("command bit changed away from a falling clock");

  a_quad_sample: assert property ( // RQ6
    @(posedge lclk) disable iff (!lrst_n)
    (run && st_q == cil_pkg::SER_DATA && fall && quad) |=> sh_q[3:0] == $past(data_in))
    else $error("quad data not shifted in four bits at a time");

endmodule

// >>> logic/cil_config_loader.sv
// Configuration image loader: APB registers, parallel and serial link logic
//
// Summary of operation
// [RQ1] Clocks per word are 1/2 for 8-bit, 1/2/4 for 16-bit and 1/4/8 for 32-bit by features.
// [RQ2] The host runs the clock at ratio times its word rate and holds each word that long.
// [RQ3] The spare clocks of each word period decrypt and process the word before the next.
// [RQ4] With a ratio above one the host gives ratio minus one clocks after the last word.
// [RQ5] 8-bit mode uses only the low eight data lines and 16-bit mode the low sixteen.
// [RQ6] Quad serial mode takes four bits per clock, single mode one line.
// [RQ7] The internal oscillator offers four serial clock settings, slowest to fastest.
// [RQ8] The fastest serial setting is not used when devices are chained.
// [RQ9] The init clock comes from the oscillator or from the user clock pin as selected.
// [RQ10] Init-done is driven low once its enabling option bit has been loaded.
// [RQ11] Serial command bits launch and flash data is sampled on the falling clock edge.
// [RQ12] In parallel mode a word is captured on a rising clock edge once per ratio period.
`timescale 1ns/10ps
module cil_config_loader (
  // System clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Link clock and parallel load pins
  input  wire logic        config_clock,
  input  wire logic        chip_enable_in_n,
  input  wire logic [31:0] parallel_data,
  // Serial flash pins
  output logic             flash_clock_out,
  output logic             memory_command_out,
  output logic             memory_command_oe,
  input  wire logic [3:0]  quad_flash_data_lines_in,
  // Init clock and init-done pin
  input  wire logic        user_clock_in,
  output logic             init_tick,
  output logic             init_done_out,
  output logic             init_done_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Register file on clk

  logic [10:0] ctrl_q, ctrl_d;
  logic [31:0] key_q, key_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] words_q, words_d;
  logic [31:0] last_q, last_d;
  logic        opt_seen_q, opt_seen_d;
  logic        hit;
  logic        wr_en;
  logic [3:0]  ratio_c;
  logic [1:0]  set_eff;

  function automatic logic addr_hit(input logic [7:0] a);
    return a == cil_pkg::OFF_CTRL || a == cil_pkg::OFF_KEY || a == cil_pkg::OFF_STAT ||
           a == cil_pkg::OFF_WORDS || a == cil_pkg::OFF_LAST;
  endfunction

  assign hit   = addr_hit(paddr);
  assign wr_en = psel && penable && pwrite && hit;

  assign ratio_c = cil_pkg::word_ratio(ctrl_q[cil_pkg::CTRL_WID_LO +: 2],
                                       ctrl_q[cil_pkg::CTRL_DCMP],
                                       ctrl_q[cil_pkg::CTRL_DCRY]); // RQ1

  // A chained load falls back one setting rather than refusing to run
  assign set_eff = (ctrl_q[cil_pkg::CTRL_CHAIN] &&
                    ctrl_q[cil_pkg::CTRL_SET_LO +: 2] == cil_pkg::SET_TOP) ?
                   cil_pkg::SET_CHAIN : ctrl_q[cil_pkg::CTRL_SET_LO +: 2]; // RQ8

  // Snapshot handshake signals
  logic        req_q, req_d;
  logic [1:0]  ack_sync_q;
  logic        ack_l_q, ack_l_d;
  logic [31:0] snap_cnt_q, snap_cnt_d;
  logic [31:0] snap_last_q, snap_last_d;
  logic        snap_opt_q, snap_opt_d;

  always_comb
  begin
    ctrl_d     = ctrl_q;
    key_d      = key_q;
    rdata_d    = rdata_q;
    words_d    = words_q;
    last_d     = last_q;
    opt_seen_d = opt_seen_q;
    req_d      = req_q;
    if (wr_en && paddr == cil_pkg::OFF_CTRL)
    begin
      ctrl_d = pwdata[cil_pkg::CTRL_BITS-1:0];
    end
    if (wr_en && paddr == cil_pkg::OFF_KEY)
    begin
      key_d = pwdata;
    end
    // Read data is fetched in the setup cycle so the answer comes from a flop
    if (psel && !penable)
    begin
      case (paddr)
        cil_pkg::OFF_CTRL:  rdata_d = {21'h000000, ctrl_q};
        cil_pkg::OFF_KEY:   rdata_d = key_q;
        cil_pkg::OFF_STAT:  rdata_d = {24'h000000, ratio_c, 2'h0,
                                       ctrl_q[cil_pkg::CTRL_RUN], opt_seen_q};
        cil_pkg::OFF_WORDS: rdata_d = words_q;
        cil_pkg::OFF_LAST:  rdata_d = last_q;
        default:            rdata_d = 32'h0000_0000;
      endcase
    end
    // Take a new snapshot each time the link side has answered
    if (ack_sync_q[1] == req_q)
    begin
      words_d    = snap_cnt_q;
      last_d     = snap_last_q;
      opt_seen_d = snap_opt_q;
      req_d      = ~req_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q     <= cil_pkg::CTRL_RESET;
      key_q      <= cil_pkg::KEY_RESET;
      rdata_q    <= 32'h0000_0000;
      words_q    <= 32'h0000_0000;
      last_q     <= 32'h0000_0000;
      opt_seen_q <= 1'b0;
      req_q      <= 1'b0;
      ack_sync_q <= 2'h0;
    end
    else
    begin
      ctrl_q     <= ctrl_d;
      key_q      <= key_d;
      rdata_q    <= rdata_d;
      words_q    <= words_d;
      last_q     <= last_d;
      opt_seen_q <= opt_seen_d;
      req_q      <= req_d;
      ack_sync_q <= {ack_sync_q[0], ack_l_q};
    end
  end

  assign prdata  = rdata_q;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  ////////////////////////////////////////////////////////////////////////////
  // Link domain reset and control crossing

  logic [1:0]  lrst_q;
  logic        lrst_n;
  logic [10:0] ctrl_s1_q, ctrl_s2_q;
  logic [1:0]  set_s1_q, set_s2_q;
  logic [31:0] key_s1_q, key_s2_q;
  logic [1:0]  req_sync_q;
  logic [2:0]  usr_sync_q;

  // Release is synchronous to the link clock, assertion is immediate
  always_ff @(posedge config_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lrst_q <= 2'h0;
    end
    else
    begin
      lrst_q <= {lrst_q[0], 1'b1};
    end
  end

  assign lrst_n = lrst_q[1];

  // Settings are quasi static: software changes them only while no load runs
  always_ff @(posedge config_clock or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      ctrl_s1_q  <= cil_pkg::CTRL_RESET;
      ctrl_s2_q  <= cil_pkg::CTRL_RESET;
      set_s1_q   <= 2'h0;
      set_s2_q   <= 2'h0;
      key_s1_q   <= cil_pkg::KEY_RESET;
      key_s2_q   <= cil_pkg::KEY_RESET;
      req_sync_q <= 2'h0;
      usr_sync_q <= 3'h0;
    end
    else
    begin
      ctrl_s1_q  <= ctrl_q;
      ctrl_s2_q  <= ctrl_s1_q;
      set_s1_q   <= set_eff;
      set_s2_q   <= set_s1_q;
      key_s1_q   <= key_q;
      key_s2_q   <= key_s1_q;
      req_sync_q <= {req_sync_q[0], req_q};
      usr_sync_q <= {usr_sync_q[1:0], user_clock_in};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parallel capture, word processing and commit on the link clock

  logic [1:0]  wid_l;
  logic        serial_l;
  logic [3:0]  ratio_l;
  logic        ce_l;
  logic [3:0]  ph_q, ph_d;
  logic [31:0] cap_q, cap_d;
  logic [31:0] in_word;
  logic        capture;
  logic        commit;
  logic [31:0] raw_word;
  logic [31:0] proc_word;
  logic [31:0] wcnt_q, wcnt_d;
  logic [31:0] wlast_q, wlast_d;
  logic        opt_q, opt_d;
  logic        ser_vld;
  logic [31:0] ser_word;
  logic        init_q, init_d;
  logic        usr_rise;

  assign wid_l    = ctrl_s2_q[cil_pkg::CTRL_WID_LO +: 2];
  assign serial_l = ctrl_s2_q[cil_pkg::CTRL_SERIAL];
  assign ratio_l  = cil_pkg::word_ratio(wid_l, ctrl_s2_q[cil_pkg::CTRL_DCMP],
                                        ctrl_s2_q[cil_pkg::CTRL_DCRY]); // RQ1
  assign ce_l     = !chip_enable_in_n && !serial_l;
  assign in_word  = cil_pkg::mask_word(parallel_data, wid_l); // RQ5
  assign capture  = ce_l && ph_q == 4'h0; // RQ12
  // Commit on the last clock of the word period, so the last word is done before any trailing clocks
  assign commit   = (ce_l && ph_q == 4'(ratio_l - 4'h1)) || (serial_l && ser_vld); // RQ3 RQ4
  assign raw_word = serial_l ? ser_word : ((ratio_l == 4'h1) ? in_word : cap_q);
  assign proc_word = ctrl_s2_q[cil_pkg::CTRL_DCRY] ? (raw_word ^ key_s2_q) : raw_word; // RQ3
  assign usr_rise = usr_sync_q[1] && !usr_sync_q[2];

  always_comb
  begin
    ph_d        = ph_q;
    cap_d       = cap_q;
    wcnt_d      = wcnt_q;
    wlast_d     = wlast_q;
    opt_d       = opt_q;
    ack_l_d     = ack_l_q;
    snap_cnt_d  = snap_cnt_q;
    snap_last_d = snap_last_q;
    snap_opt_d  = snap_opt_q;
    if (!ce_l)
    begin
      ph_d = 4'h0;
    end
    else if (ph_q == 4'(ratio_l - 4'h1))
    begin
      ph_d = 4'h0; // RQ12
    end
    else
    begin
      ph_d = ph_q + 4'h1; // RQ3
    end
    if (capture)
    begin
      cap_d = in_word; // RQ12
    end
    if (commit)
    begin
      wcnt_d  = wcnt_q + 32'h0000_0001;
      wlast_d = proc_word;
      if (wcnt_q == 32'h0000_0000 && proc_word[cil_pkg::OPT_INIT_DONE])
      begin
        opt_d = 1'b1; // RQ10
      end
    end
    if (req_sync_q[1] != ack_l_q)
    begin
      snap_cnt_d  = wcnt_q;
      snap_last_d = wlast_q;
      snap_opt_d  = opt_q;
      ack_l_d     = req_sync_q[1];
    end
    // Init clock enable from the oscillator or the synchronised user clock
    init_d = ctrl_s2_q[cil_pkg::CTRL_USRCLK] ? usr_rise : 1'b1; // RQ9
  end

  always_ff @(posedge config_clock or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      ph_q        <= 4'h0;
      cap_q       <= 32'h0000_0000;
      wcnt_q      <= 32'h0000_0000;
      wlast_q     <= 32'h0000_0000;
      opt_q       <= 1'b0;
      ack_l_q     <= 1'b0;
      snap_cnt_q  <= 32'h0000_0000;
      snap_last_q <= 32'h0000_0000;
      snap_opt_q  <= 1'b0;
      init_q      <= 1'b0;
    end
    else
    begin
      ph_q        <= ph_d;
      cap_q       <= cap_d;
      wcnt_q      <= wcnt_d;
      wlast_q     <= wlast_d;
      opt_q       <= opt_d;
      ack_l_q     <= ack_l_d;
      snap_cnt_q  <= snap_cnt_d;
      snap_last_q <= snap_last_d;
      snap_opt_q  <= snap_opt_d;
      init_q      <= init_d;
    end
  end

  assign init_tick     = init_q;
  assign init_done_out = 1'b0;
  assign init_done_oe  = opt_q; // RQ10

  ////////////////////////////////////////////////////////////////////////////
  // Serial flash reader

  cil_serial_reader u_serial (
    .lclk      (config_clock),
    .lrst_n    (lrst_n),
    .run       (serial_l && ctrl_s2_q[cil_pkg::CTRL_RUN]),
    .quad      (ctrl_s2_q[cil_pkg::CTRL_QUAD]),
    .clkset    (set_s2_q),
    .flash_clk (flash_clock_out),
    .cmd_out   (memory_command_out),
    .cmd_oe    (memory_command_oe),
    .data_in   (quad_flash_data_lines_in),
    .word_vld  (ser_vld),
    .word      (ser_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_ratio_table: assert property ( // RQ1
    @(posedge clk) disable iff (!rst_n)
    (ctrl_q[1:0] == cil_pkg::WID_32 && ctrl_q[cil_pkg::CTRL_DCMP]) |-> ratio_c == 4'h8)
    else $error("32-bit compressed ratio is not eight");

  a_chain_setting: assert property ( // RQ8
    @(posedge clk) disable iff (!rst_n)
    ctrl_q[cil_pkg::CTRL_CHAIN] |-> set_eff != cil_pkg::SET_TOP)
    else $error("fastest serial clock selected in a chain");

  a_narrow_lines: assert property ( // RQ5
    @(posedge config_clock) disable iff (!lrst_n)
    (capture && wid_l == cil_pkg::WID_8) |=> cap_q[31:8] == 24'h000000)
    else $error("upper data lines captured in 8-bit mode");

  a_word_period: assert property ( // RQ3
    @(posedge config_clock) disable iff (!lrst_n)
    (capture && ratio_l == 4'h4) ##1 ce_l[*3] |-> commit && !capture)
    else $error("word not committed at the end of its period");

  a_one_capture: assert property ( // RQ12
    @(posedge config_clock) disable iff (!lrst_n)
    (capture && ratio_l == 4'h2) |=> !capture)
    else $error("second capture inside one word period");

  a_init_done_low: assert property ( // RQ10
    @(posedge config_clock) disable iff (!lrst_n)
    (commit && wcnt_q == 32'h0000_0000 && proc_word[cil_pkg::OPT_INIT_DONE])
    |-> ##1 (init_done_oe && !init_done_out))
    else $error("init-done not driven low after its option bit");

  a_init_source: assert property ( // RQ9
    @(posedge config_clock) disable iff (!lrst_n)
    (ctrl_s2_q[cil_pkg::CTRL_USRCLK] && !usr_rise) |=> !init_tick)
    else $error("init tick without a user clock edge");

endmodule

// >>> test/cil_flash_model.sv
// Serial flash model answering the read command
`timescale 1ns/10ps
module cil_flash_model (
  // Flash pins
  input  wire logic       sck,
  input  wire logic       cmd,
  input  wire logic       cmd_oe,
  output logic [3:0]      dq,
  // Command seen
  output logic [7:0]      cmd_seen
);
  localparam logic [31:0] PAT = 32'ha5c3_96f1;
  logic [7:0] sh;
  int         nb;
  int         nd;
  logic       armed;
  initial
  begin
    dq = 4'h0;
    sh = 8'h00;
    cmd_seen = 8'h00;
    nb = 0;
    nd = 0;
    armed = 0;
  end
  always @(posedge cmd_oe)
  begin
    nb = 0;
    nd = 0;
    armed = 0;
  end
  // The first command bit is launched on a fall, so rises before it carry nothing
  always @(negedge sck)
  begin
    if (cmd_oe)
      armed = 1;
  end
  // Changes on the rise, so data is settled at the device's falling sample
  always @(posedge sck)
  begin
    if (armed && nb < 8)
    begin
      sh = {sh[6:0], cmd};
      nb++;
      cmd_seen = sh;
      dq <= ~dq;
    end
    else if (armed && cmd_seen === 8'heb)
    begin
      // Quad words are the inverse pattern so they differ from single-line words
      dq <= ~PAT[31 - 4 * (nd % 8) -: 4];
      nd++;
    end
    else if (armed)
    begin
      dq <= {~dq[3:2], PAT[31 - (nd % 32)], ~dq[0]};
      nd++;
    end
  end
endmodule

// >>> test/testbench.sv
// Self-checking bench for the configuration image loader
`timescale 1ns/10ps
module testbench;
  logic        clk = 0;
  logic        rst_n = 0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        lclk = 0;
  logic        len = 1;
  logic        nce_n = 1;
  logic [31:0] pd = 32'h0;
  logic        fck;
  logic        mco;
  logic        moe;
  logic [3:0]  dq;
  logic        ucl = 0;
  logic        tick;
  logic        ido;
  logic        idoe;
  logic [7:0]  cseen;
  logic [31:0] r;
  logic        e;
  int          bad_count = 0;
  int          checks_done = 0;
  always #50 clk = ~clk;
  // Host clock stands low whenever the host has stopped it
  initial #3 forever #6 lclk = len ? ~lclk : 1'b0;
  always @(posedge clk) ucl <= ~ucl;
  cil_config_loader cil_config_loader_i (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .config_clock(lclk), .chip_enable_in_n(nce_n), .parallel_data(pd),
    .flash_clock_out(fck), .memory_command_out(mco), .memory_command_oe(moe),
    .quad_flash_data_lines_in(dq), .user_clock_in(ucl), .init_tick(tick),
    .init_done_out(ido), .init_done_oe(idoe));
  cil_flash_model cil_flash_model_i (.sck(fck), .cmd(mco), .cmd_oe(moe), .dq(dq),
    .cmd_seen(cseen));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    if (bad_count == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
      bad_count++;
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // Host side: each word held for ratio clocks, then 100 clocks with chip enable high after the last
  task automatic load(input logic [31:0] w0, input logic [31:0] w1, input int rt);
    len = 1;
    repeat (6) @(posedge lclk);
    nce_n <= 0;
    pd <= w0;
    repeat (rt) @(posedge lclk);
    pd <= w1;
    repeat (rt) @(posedge lclk);
    nce_n <= 1;
    pd <= ~w1;
    // Status crosses only while the link clock runs, so idle it before stopping
    repeat (100) @(posedge lclk);
    len = 0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    apb(cil_pkg::OFF_CTRL, 0, 0);
    chk(r, 32'h0);
    apb(cil_pkg::OFF_KEY, 0, 0);
    chk(r, 32'h0);
    apb(8'h3c, 1, 32'h1234_5678);
    apb(8'h3c, 0, 0);
    chk({r[30:0], e}, 32'h1);
  endtask
  task automatic t_ratio;
    logic [3:0] cf[8] = '{4'h0, 4'h4, 4'h8, 4'h1, 4'h9, 4'h5, 4'ha, 4'h6};
    logic [3:0] ex[8] = '{4'h1, 4'h2, 4'h1, 4'h1, 4'h2, 4'h4, 4'h4, 4'h8};
    foreach (cf[i])
    begin
      apb(cil_pkg::OFF_CTRL, 1, {28'h0, cf[i]});
      repeat (12) @(posedge clk);
      apb(cil_pkg::OFF_STAT, 0, 0);
      chk(r[7:4], ex[i]);
    end
  endtask
  task automatic t_par;
    apb(cil_pkg::OFF_CTRL, 1, 32'h0000_0009);
    apb(cil_pkg::OFF_KEY, 1, 32'h0000_5a5a);
    chk(idoe, 0);
    load(32'hdead_1235, 32'hbeef_8001, 2);
    repeat (12) @(posedge clk);
    apb(cil_pkg::OFF_WORDS, 0, 0);
    chk(r, 32'h2);
    apb(cil_pkg::OFF_LAST, 0, 0);
    chk(r, 32'h0000_da5b);
    chk({ido, idoe}, 2'b01);
    apb(cil_pkg::OFF_CTRL, 1, 32'h0000_000a);
    load(32'h0f0f_1234, 32'h8765_4321, 4);
    repeat (12) @(posedge clk);
    apb(cil_pkg::OFF_WORDS, 0, 0);
    chk(r, 32'h4);
    apb(cil_pkg::OFF_LAST, 0, 0);
    chk(r, 32'h8765_197b);
    apb(cil_pkg::OFF_CTRL, 1, 32'h0000_0004);
    load(32'hffff_ff3c, 32'hffff_ffc5, 2);
    repeat (12) @(posedge clk);
    apb(cil_pkg::OFF_WORDS, 0, 0);
    chk(r, 32'h6);
    apb(cil_pkg::OFF_LAST, 0, 0);
    chk(r, 32'h0000_00c5);
  endtask
  task automatic t_init;
    int n;
    len = 1;
    apb(cil_pkg::OFF_CTRL, 1, 32'h0000_0200);
    repeat (2) @(posedge clk);
    n = 0;
    repeat (200)
    begin
      @(negedge lclk);
      if (tick === 1'b1)
        n++;
    end
    chk(n >= 11 && n <= 13, 1);
    apb(cil_pkg::OFF_CTRL, 1, 32'h0000_0000);
    repeat (2) @(posedge clk);
    n = 0;
    repeat (200)
    begin
      @(negedge lclk);
      if (tick === 1'b1)
        n++;
    end
    chk(n, 200);
  endtask
  task automatic half(input logic [31:0] c, input int exp);
    int n;
    apb(cil_pkg::OFF_CTRL, 1, c);
    repeat (4) @(posedge fck);
    n = 0;
    while (fck === 1'b1 && n < 40)
    begin
      @(posedge lclk);
      #1;
      n++;
    end
    chk(n, exp);
  endtask
  task automatic t_ser;
    len = 1;
    half(32'h0000_0410, 8);
    repeat (800) @(posedge lclk);
    chk(cseen, cil_pkg::CMD_READ_X1);
    apb(cil_pkg::OFF_LAST, 0, 0);
    chk(r, 32'ha5c3_96f1);
    half(32'h0000_0450, 4);
    half(32'h0000_0490, 2);
    half(32'h0000_04d0, 1);
    half(32'h0000_05d0, 2);
    apb(cil_pkg::OFF_CTRL, 1, 32'h0000_0030);
    half(32'h0000_0470, 4);
    repeat (400) @(posedge lclk);
    chk(cseen, cil_pkg::CMD_READ_X4);
    apb(cil_pkg::OFF_LAST, 0, 0);
    chk(r, 32'h5a3c_690e);
  endtask
  initial
  begin
    #500_000;
    bad_count++;
    stop_test();
  end
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1;
    t_regs();
    t_ratio();
    t_par();
    t_init();
    t_ser();
    stop_test();
  end
endmodule
